// >>> include/tcr_pkg.sv
// Purpose: shared constants and types of the rule lookup engine
// Assumes: one 40 MHz clock, synchronous active-high reset
// Notes:   addresses are word addresses into the shared rule memory

package tcr_pkg;

  // memory geometry
  localparam int unsigned ENTRY_W     = 36;    // entry data and mask bits per address
  localparam int unsigned ACTION_W    = 70;    // action bits per address
  localparam int unsigned BLOCK_WORDS = 1024;  // rule addresses per resource block
  localparam int unsigned MEM_WORDS   = 8192;  // whole rule address space
  localparam int unsigned ADDR_W      = 13;    // word address width
  localparam int unsigned END_W       = 14;    // address width that can hold the end bound
  localparam int unsigned BLK_W       = 3;     // resource block index
  localparam int unsigned BLKN_W      = 4;     // resource block count (0..8)
  localparam int unsigned BLK_SHIFT   = 10;    // log2 of block size

  // key and action assembly
  localparam int unsigned MAX_WORDS   = 16;              // widest rule in addresses
  localparam int unsigned KEY_W       = 576;             // widest key, 16 addresses of 36 bits
  localparam int unsigned ACT_OUT_W   = 280;             // widest assembled action
  localparam int unsigned KPTR_W      = 10;              // key bit pointer
  localparam int unsigned APTR_W      = 9;               // action bit pointer
  localparam int unsigned OFF_W       = 4;               // address offset inside a rule
  localparam int unsigned WORDS_W     = 5;               // rule length in addresses (1..16)
  localparam int unsigned AWORDS_W    = 3;               // action length in addresses (0..4)
  localparam int unsigned TGW_W       = 3;               // type-group width field
  localparam int unsigned TG_W        = 5;               // widest type-group value
  localparam int unsigned DEF_IDX_W   = 5;               // default rule index

  // type-group widths away from offset 0
  localparam logic [TGW_W-1:0] TGW_NONE      = 3'h0;
  localparam logic [TGW_W-1:0] CLS_TGW_ODD   = 3'h1;  // offsets 1,3,5,...
  localparam logic [TGW_W-1:0] CLS_TGW_TWO   = 3'h2;  // offsets 2,6,10,14
  localparam logic [TGW_W-1:0] CLS_TGW_FOUR  = 3'h3;  // offsets 4,12
  localparam logic [TGW_W-1:0] CLS_TGW_EIGHT = 3'h4;  // offset 8
  localparam logic [TGW_W-1:0] ACL_TGW_FOUR  = 3'h1;  // offsets 4,12
  localparam logic [TGW_W-1:0] ACL_TGW_EIGHT = 3'h2;  // offset 8
  localparam logic [TGW_W-1:0] TGW_STEP      = 3'h1;  // offset-0 width step per size

  // action lengths in addresses
  localparam logic [AWORDS_W-1:0] AWORDS_NONE = 3'h0;
  localparam logic [AWORDS_W-1:0] AWORDS_X4   = 3'h4;

  // default rule placement
  localparam logic [ADDR_W-1:0]    CLS0_DEF_BASE = 13'h1800;  // 6144
  localparam logic [ADDR_W-1:0]    CLS1_DEF_BASE = 13'h19e0;  // 6624
  localparam logic [ADDR_W-1:0]    CLS2_DEF_BASE = 13'h1bc0;  // 7104
  localparam logic [ADDR_W-1:0]    ACL_DEF_BASE  = 13'h1da0;  // 7584
  localparam int unsigned          DEF_SHIFT     = 4;         // rules are 16 addresses apart
  localparam logic [DEF_IDX_W-1:0] CLS_DEF_NUM   = 5'h1e;     // 30 per instance
  localparam logic [DEF_IDX_W-1:0] ACL_DEF_NUM   = 5'h10;     // 16

  // which matcher a lookup goes to
  typedef enum logic [1:0] {
    TCR_CLS0 = 2'h0,
    TCR_CLS1 = 2'h1,
    TCR_CLS2 = 2'h2,
    TCR_ACL  = 2'h3
  } tcr_matcher_t;

  // rule sizes, encoded as log2 of the address count
  typedef enum logic [2:0] {
    TCR_X1  = 3'h0,
    TCR_X2  = 3'h1,
    TCR_X4  = 3'h2,
    TCR_X8  = 3'h3,
    TCR_X16 = 3'h4
  } tcr_size_t;

  // lookup sequencer, gray along idle-scan-act-done
  typedef enum logic [1:0] {
    TCR_ST_IDLE = 2'b00,
    TCR_ST_SCAN = 2'b01,
    TCR_ST_ACT  = 2'b11,
    TCR_ST_DONE = 2'b10
  } tcr_state_t;

endpackage

// >>> include/tcr_layout_if.sv
// Purpose: carries a layout query and its answer between sequencer and layout logic
// Assumes: purely combinational answer
// Notes:   seq drives the query, lay answers it

`timescale 1ns/10ps

interface tcr_layout_if;
  import tcr_pkg::*;

  logic                  is_acl;      // query is for the access-list matcher
  tcr_size_t             size;        // rule size
  logic [OFF_W-1:0]      offset;      // address offset inside the rule
  logic                  size_ok;     // size supported by this matcher
  logic [WORDS_W-1:0]    rule_words;  // addresses the entry spans
  logic [AWORDS_W-1:0]   act_words;   // addresses carrying action bits
  logic [TGW_W-1:0]      entry_tgw;   // entry type-group width at this offset
  logic [TG_W-1:0]       entry_tg;    // entry type-group value at this offset
  logic [TGW_W-1:0]      act_tgw;     // action type-group width at this offset
  logic [TG_W-1:0]       act_tg;      // action type-group value at this offset

  modport seq (output is_acl, size, offset,
               input  size_ok, rule_words, act_words, entry_tgw, entry_tg, act_tgw, act_tg);
  modport lay (input  is_acl, size, offset,
               output size_ok, rule_words, act_words, entry_tgw, entry_tg, act_tgw, act_tg);
endinterface

// >>> hw/tcr_layout.sv
// Purpose: type-group widths and values and rule lengths per matcher, size and offset
// Assumes: combinational, answered in the same cycle
// Notes:   bit positions follow from summing the free bits of earlier offsets

`timescale 1ns/10ps

module tcr_layout (
  // query and answer
  tcr_layout_if.lay lay
);
  import tcr_pkg::*;

  // classification entry widths: size-dependent at 0, then by lowest set offset bit
  function automatic logic [TGW_W-1:0] cls_tgw(input tcr_size_t sz, input logic [OFF_W-1:0] off);
    if (off == '0)       return TGW_W'(sz) + TGW_STEP;
    else if (off[0])     return CLS_TGW_ODD;
    else if (off[1])     return CLS_TGW_TWO;
    else if (off[2])     return CLS_TGW_FOUR;
    else                 return CLS_TGW_EIGHT;
  endfunction

  // access-list entry widths: none except offsets 0, 4, 8 and 12
  function automatic logic [TGW_W-1:0] acl_tgw(input tcr_size_t sz, input logic [OFF_W-1:0] off);
    if (off == '0)                   return TGW_W'(sz) - TGW_STEP;
    else if (off[1:0] != 2'h0)       return TGW_NONE;
    else if (off[2])                 return ACL_TGW_FOUR;
    else                             return ACL_TGW_EIGHT;
  endfunction

  // offset 0 carries a single one at the top of the field, all others are zeros
  function automatic logic [TG_W-1:0] tg_value(input logic [TGW_W-1:0] w,
                                               input logic [OFF_W-1:0] off);
    if (off == '0 && w != TGW_NONE) return TG_W'(1) << (w - TGW_STEP);
    else                            return '0;
  endfunction

  wire             cls_ok  = (lay.size <= TCR_X16);
  wire             acl_ok  = (lay.size >= TCR_X4) && (lay.size <= TCR_X16);
  wire             narrow  = (lay.size <= TCR_X4);
  wire [TGW_W-1:0] cls_w   = cls_tgw(lay.size, lay.offset);
  wire [TGW_W-1:0] acl_w   = acl_tgw(lay.size, lay.offset);

  assign lay.size_ok    = lay.is_acl ? acl_ok : cls_ok;
  assign lay.rule_words = WORDS_W'(1) << lay.size;
  assign lay.entry_tgw  = lay.is_acl ? acl_w : cls_w;
  assign lay.entry_tg   = tg_value(lay.entry_tgw, lay.offset);
  // classification actions share the entry pattern for offsets 0..3
  assign lay.act_tgw    = lay.is_acl ? TGW_NONE : cls_w;
  assign lay.act_tg     = tg_value(lay.act_tgw, lay.offset);
  // wide classification rules and wide access-list rules carry no action
  assign lay.act_words  = !narrow ? AWORDS_NONE :
                          lay.is_acl ? ((lay.size == TCR_X4) ? AWORDS_X4 : AWORDS_NONE) :
                          AWORDS_W'(lay.rule_words);

endmodule // tcr_layout

// >>> hw/tcr_default.sv
// Purpose: start address of the default rule a lookup falls back to
// Assumes: combinational
// Notes:   an index past the last default rule is held at the last one

`timescale 1ns/10ps

module tcr_default (
  // selection
  input  tcr_pkg::tcr_matcher_t             matcher,
  input  wire logic [tcr_pkg::DEF_IDX_W-1:0] index,
  // answer
  output logic [tcr_pkg::ADDR_W-1:0]        addr
);
  import tcr_pkg::*;

  wire             is_acl = (matcher == TCR_ACL);
  wire [DEF_IDX_W-1:0] num = is_acl ? ACL_DEF_NUM : CLS_DEF_NUM;
  // clamp so a bad index can never land in another instance's defaults
  wire [DEF_IDX_W-1:0] idx = (index < num) ? index : num - DEF_IDX_W'(1);
  wire [ADDR_W-1:0]    base = (matcher == TCR_CLS0) ? CLS0_DEF_BASE :
                              (matcher == TCR_CLS1) ? CLS1_DEF_BASE :
                              (matcher == TCR_CLS2) ? CLS2_DEF_BASE :
                              ACL_DEF_BASE;

  assign addr = base + (ADDR_W'(idx) << DEF_SHIFT);

endmodule // tcr_default

// >>> hw/tcr_lookup.sv
// Purpose: rule memory and sequential ternary lookup with default-rule fallback
// Assumes: inputs synchronous to clk; block allocation held stable during a lookup
// Notes:   entries are searched one address per cycle, lowest rule address first
//
// Behaviour
// - classification entry and action bits packed per offset
// - classification X4 actions span four; X8/X16 none
// - classification miss hits the chosen default rule
// - no classification blocks means default always hit
// - instance zero: 30 defaults from 6144, step 16
// - instance one: 30 defaults from 6624, step 16
// - instance two: 30 defaults from 7104, step 16
// - access-list: 1024 addresses per allocated block
// - access-list entry bits packed per offset; action bits carry no type-group
// - access-list: 16 defaults from 7584, step 16
// - access-list default chosen with the search, used on miss
// - no access-list blocks means default always hit

`timescale 1ns/10ps

module tcr_lookup #(
  parameter int unsigned NUM_WORDS = tcr_pkg::MEM_WORDS  // rule memory depth
) (
  // clock and reset
  input  wire logic                             clk,
  input  wire logic                             sys_rst,
  // resource blocks owned by each matcher, indexed by matcher code
  input  wire logic [3:0][tcr_pkg::BLK_W-1:0]   blk_first,
  input  wire logic [3:0][tcr_pkg::BLKN_W-1:0]  blk_count,
  // rule writes from software
  input  wire logic                             wr_en,
  input  wire logic [tcr_pkg::ADDR_W-1:0]       wr_addr,
  input  wire logic [tcr_pkg::ENTRY_W-1:0]      wr_entry,
  input  wire logic [tcr_pkg::ENTRY_W-1:0]      wr_mask,
  input  wire logic [tcr_pkg::ACTION_W-1:0]     wr_action,
  // hit counter read
  input  wire logic [tcr_pkg::ADDR_W-1:0]       cnt_addr,
  output logic                                  cnt_q,
  // lookup request from the analyzer
  input  wire logic                             lk_valid,
  output logic                                  lk_ready_q,
  input  tcr_pkg::tcr_matcher_t                 lk_matcher,
  input  tcr_pkg::tcr_size_t                    lk_size,
  input  wire logic [tcr_pkg::DEF_IDX_W-1:0]    lk_default,
  input  wire logic [tcr_pkg::KEY_W-1:0]        lk_key,
  // lookup result
  output logic                                  res_valid_q,
  output logic                                  res_hit_q,
  output logic [tcr_pkg::ADDR_W-1:0]            res_addr_q,
  output logic [tcr_pkg::ACT_OUT_W-1:0]         res_action_q
);
  import tcr_pkg::*;

  // rule memory, data words are not reset; software initialises before use
  logic [ENTRY_W-1:0]  mem_entry [NUM_WORDS];   // entry data
  logic [ENTRY_W-1:0]  mem_mask  [NUM_WORDS];   // 1 = don't care
  logic [ACTION_W-1:0] mem_act   [NUM_WORDS];   // action data
  logic [NUM_WORDS-1:0] mem_cnt_q;              // saturating hit counters

  // sequencer state
  tcr_state_t           state_q, state_d;      // lookup phase
  logic                 acl_q;                  // lookup targets the access list
  tcr_size_t            size_q;                 // entry size, then action size
  logic [KEY_W-1:0]     key_q;                  // key held for the whole search
  logic [ADDR_W-1:0]    base_q;                 // start address of rule under test
  logic [END_W-1:0]     end_q;                  // first address past the region
  logic [OFF_W-1:0]     off_q;                  // offset inside the rule
  logic [KPTR_W-1:0]    kptr_q;                 // next key bit to compare
  logic [APTR_W-1:0]    aptr_q;                 // next action bit to fill
  logic [ADDR_W-1:0]    def_q;                  // default rule picked with the request
  logic [ADDR_W-1:0]    rule_q;                 // rule whose action is being read
  logic                 hit_q;                  // an entry matched
  logic [ACT_OUT_W-1:0] act_q;                  // action under assembly

  // inserts the type-group under the next slice of key bits
  function automatic logic [ENTRY_W-1:0] key_word(input logic [KEY_W-1:0] key,
                                                  input logic [KPTR_W-1:0] ptr,
                                                  input logic [TGW_W-1:0] tgw,
                                                  input logic [TG_W-1:0] tg);
    logic [KEY_W-1:0]   sh;
    logic [ENTRY_W-1:0] data;
    sh   = key >> ptr;
    data = sh[ENTRY_W-1:0] << tgw;
    return data | ENTRY_W'(tg);
  endfunction

  // layout lookup for the current offset
  tcr_layout_if lay_if ();
  tcr_layout u_layout (
    .lay (lay_if.lay)
  );
  assign lay_if.is_acl = (state_q == TCR_ST_IDLE) ? (lk_matcher == TCR_ACL) : acl_q;
  assign lay_if.size   = (state_q == TCR_ST_IDLE) ? lk_size : size_q;
  assign lay_if.offset = off_q;

  // default rule address for the incoming request
  logic [ADDR_W-1:0] def_addr;                  // picked at request time
  tcr_default u_default (
    .matcher (lk_matcher),
    .index   (lk_default),
    .addr    (def_addr)
  );

  // request acceptance and region of the requested matcher
  wire                 take     = lk_valid && lk_ready_q;
  wire [BLK_W-1:0]     r_first  = blk_first[lk_matcher];
  wire [BLKN_W-1:0]    r_count  = blk_count[lk_matcher];
  wire [END_W-1:0]     r_start  = END_W'(r_first) << BLK_SHIFT;
  wire [END_W-1:0]     r_end    = END_W'(BLKN_W'(r_first) + r_count) << BLK_SHIFT;
  // a region with no blocks, or too short for one rule, can only miss
  wire                 r_fits   = (r_start + END_W'(lay_if.rule_words)) <= r_end;
  wire                 r_search = lay_if.size_ok && (r_count != '0) && r_fits;

  // one-address compare during the scan
  wire [ADDR_W-1:0]    scan_addr = base_q + ADDR_W'(off_q);
  wire [ENTRY_W-1:0]   kword     = key_word(key_q, kptr_q, lay_if.entry_tgw, lay_if.entry_tg);
  wire                 word_ok   = ((mem_entry[scan_addr] ^ kword) & ~mem_mask[scan_addr]) == '0;
  wire                 last_off  = (WORDS_W'(off_q) + WORDS_W'(1)) == lay_if.rule_words;
  wire [END_W-1:0]     next_base = END_W'(base_q) + END_W'(lay_if.rule_words);
  wire                 next_fits = (next_base + END_W'(lay_if.rule_words)) <= end_q;
  wire                 rule_hit  = word_ok && last_off;
  wire                 rule_miss = !word_ok && !next_fits;
  wire [KPTR_W-1:0]    kstep     = KPTR_W'(ENTRY_W) - KPTR_W'(lay_if.entry_tgw);

  // action read of the selected rule
  wire [ADDR_W-1:0]    act_addr  = rule_q + ADDR_W'(off_q);
  wire [ACTION_W-1:0]  act_bits  = mem_act[act_addr] >> lay_if.act_tgw;
  wire [ACT_OUT_W-1:0] act_slice = ACT_OUT_W'(act_bits) << aptr_q;
  wire [APTR_W-1:0]    astep     = APTR_W'(ACTION_W) - APTR_W'(lay_if.act_tgw);
  wire                 act_none  = lay_if.act_words == AWORDS_NONE;
  wire                 act_last  = act_none ||
                                   ((AWORDS_W'(off_q) + AWORDS_W'(1)) == lay_if.act_words);

  // next phase of the lookup
  always_comb begin
    state_d = state_q;
    case (state_q)
      TCR_ST_IDLE: begin
        if (take) begin
          state_d = r_search ? TCR_ST_SCAN : TCR_ST_ACT;
        end
      end
      TCR_ST_SCAN: begin
        if (rule_hit || rule_miss) begin
          state_d = TCR_ST_ACT;
        end
      end
      TCR_ST_ACT: begin
        if (act_last) begin
          state_d = TCR_ST_DONE;
        end
      end
      TCR_ST_DONE: begin
        state_d = TCR_ST_IDLE;
      end
      default: begin
        state_d = TCR_ST_IDLE;
      end
    endcase
  end

  // phase register; ready mirrors the idle phase so it stays a flop
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q    <= TCR_ST_IDLE;
      lk_ready_q <= 1'b0;
    end else begin
      state_q    <= state_d;
      lk_ready_q <= (state_d == TCR_ST_IDLE);
    end
  end

  // request capture; the default rule is fixed here, together with the search
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      acl_q <= 1'b0;
      key_q <= '0;
      def_q <= '0;
      end_q <= '0;
    end else if (take) begin
      acl_q <= (lk_matcher == TCR_ACL);
      key_q <= lk_key;
      def_q <= def_addr;
      end_q <= r_end;
    end
  end

  // walk through rules and offsets
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      base_q <= '0;
      off_q  <= '0;
      kptr_q <= '0;
      aptr_q <= '0;
      rule_q <= '0;
      hit_q  <= 1'b0;
      size_q <= TCR_X1;
    end else if (take) begin
      base_q <= ADDR_W'(r_start);
      off_q  <= '0;
      kptr_q <= '0;
      aptr_q <= '0;
      hit_q  <= 1'b0;
      // an unsearchable lookup reads the default rule at once
      size_q <= r_search ? lk_size : TCR_X4;
      rule_q <= def_addr;
    end else if (state_q == TCR_ST_SCAN) begin
      if (rule_hit) begin
        rule_q <= base_q;
        hit_q  <= 1'b1;
        off_q  <= '0;
      end else if (rule_miss) begin
        // nothing matched: fall back to the default rule      
        rule_q <= def_q;
        size_q <= TCR_X4;
        off_q  <= '0;
      end else if (word_ok) begin
        off_q  <= off_q + OFF_W'(1);
        kptr_q <= kptr_q + kstep;
      end else begin
        // mismatch: next rule of the same size
        base_q <= ADDR_W'(next_base);
        off_q  <= '0;
        kptr_q <= '0;
      end
    end else if (state_q == TCR_ST_ACT) begin
      off_q  <= off_q + OFF_W'(1);
      aptr_q <= aptr_q + astep;
    end
  end

  // action assembly, cleared for every new lookup
  always_ff @(posedge clk) begin
    if (sys_rst || take) begin
      act_q <= '0;
    end else if (state_q == TCR_ST_ACT && !act_none) begin
      act_q <= act_q | act_slice;
    end
  end

  // result, valid for one cycle as the lookup closes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      res_valid_q  <= 1'b0;
      res_hit_q    <= 1'b0;
      res_addr_q   <= '0;
      res_action_q <= '0;
    end else begin
      res_valid_q <= (state_q == TCR_ST_DONE);
      if (state_q == TCR_ST_DONE) begin
        res_hit_q    <= hit_q;
        res_addr_q   <= rule_q;
        res_action_q <= act_q;
      end
    end
  end

  // rule memory writes from software
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem_entry[wr_addr] <= wr_entry;
      mem_mask[wr_addr]  <= wr_mask;
      mem_act[wr_addr]   <= wr_action;
    end
  end

  // counters: a write clears, a hit sets, and the hit wins the same cycle
  wire cnt_set = (state_q == TCR_ST_DONE);
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mem_cnt_q <= '0;
      cnt_q     <= 1'b0;
    end else begin
      for (int i = 0; i < NUM_WORDS; i++) begin
        if (cnt_set && rule_q == ADDR_W'(i)) begin
          mem_cnt_q[i] <= 1'b1;
        end else if (wr_en && wr_addr == ADDR_W'(i)) begin
          mem_cnt_q[i] <= 1'b0;
        end
      end
      cnt_q <= mem_cnt_q[cnt_addr];
    end
  end

endmodule // tcr_lookup

// >>> test/tcr_lookup_props.sv
// Purpose: port-level timing, region and default-address checks of the lookup engine
// Assumes: one clock, synchronous active-high reset
// Notes:   the taken request is latched to judge its result

`timescale 1ns/10ps

module tcr_lookup_props import tcr_pkg::*; (
  // clock, reset and handshake
  input wire logic                clk, sys_rst, lk_valid, lk_ready_q,
  input tcr_matcher_t             lk_matcher,
  input tcr_size_t                lk_size,
  input wire logic [DEF_IDX_W-1:0] lk_default,
  input wire logic [3:0][BLK_W-1:0]  blk_first,
  input wire logic [3:0][BLKN_W-1:0] blk_count,
  // results and counter
  input wire logic                res_valid_q, res_hit_q, cnt_q,
  input wire logic [ADDR_W-1:0]   res_addr_q, cnt_addr
);
  tcr_matcher_t m_q;  // matcher of the lookup in flight
  tcr_size_t    s_q;  // its size
  logic [4:0]   d_q;  // its default index
  wire logic take = lk_valid && lk_ready_q;
  // latch request fields on the take edge
  always_ff @(posedge clk) begin
    if (take) begin
      m_q <= lk_matcher;
      s_q <= lk_size;
      d_q <= lk_default;
    end
  end
  wire logic acl = (m_q == TCR_ACL);
  // index clamps at the last default rule
  wire logic [4:0] dn = acl ? (d_q > 5'hf ? 5'hf : d_q) : (d_q > 5'h1d ? 5'h1d : d_q);
  wire logic [12:0] base = acl ? 13'h1da0 : 13'h1800 + 13'(480 * m_q);
  wire logic [12:0] def_a = base + {4'h0, dn, 4'h0};
  wire logic [13:0] lo = {1'b0, blk_first[m_q], 10'h0};
  wire logic [13:0] hi = lo + {blk_count[m_q], 10'h0};
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_valid_one_pulse: assert property (res_valid_q |=> !res_valid_q) else $error("valid too long");
  a_ready_drops_take: assert property (take |=> !lk_ready_q) else $error("ready stayed high");
  a_ready_with_result: assert property (res_valid_q |-> lk_ready_q) else $error("ready late");
  a_acl_default_addr: assert property (res_valid_q && !res_hit_q && acl |-> res_addr_q == def_a)
    else $error("acl default address wrong");
  a_cls_default_addr: assert property (res_valid_q && !res_hit_q && !acl |-> res_addr_q == def_a)
    else $error("cls default address wrong");
  a_acl_empty_miss: assert property (take && lk_matcher == TCR_ACL && blk_count[3] == 4'h0
    |-> ##6 res_valid_q && !res_hit_q) else $error("empty acl not default");
  a_cls_empty_miss: assert property (take && lk_matcher != TCR_ACL && blk_count[lk_matcher] == 4'h0
    |-> ##6 res_valid_q && !res_hit_q) else $error("empty cls not default");
  a_acl_small_size: assert property (take && lk_matcher == TCR_ACL && lk_size < TCR_X4
    |-> ##6 res_valid_q && !res_hit_q) else $error("acl small size searched");
  a_hit_in_region: assert property (res_valid_q && res_hit_q |-> {1'b0, res_addr_q} >= lo &&
    {1'b0, res_addr_q} < hi) else $error("hit outside region");
  a_hit_size_aligned: assert property (res_valid_q && res_hit_q
    |-> (res_addr_q & ((13'h1 << s_q) - 13'h1)) == 13'h0) else $error("hit unaligned");
  a_counter_set_hit: assert property (res_valid_q && cnt_addr == res_addr_q |=> cnt_q)
    else $error("counter not set");
endmodule // tcr_lookup_props

bind tcr_lookup tcr_lookup_props p_u (.clk, .sys_rst, .lk_valid, .lk_ready_q, .lk_matcher,
  .lk_size, .lk_default, .blk_first, .blk_count, .res_valid_q, .res_hit_q, .cnt_q,
  .res_addr_q, .cnt_addr);

// >>> test/tcr_analyzer.sv
// Purpose: analyzer model presenting lookup keys one at a time
// Assumes: request taken on an edge with ready high
// Notes:   key is inverted once released so stale data never looks valid

`timescale 1ns/10ps

module tcr_analyzer import tcr_pkg::*; (
  input  wire logic            clk, lk_ready_q,
  output logic                 lk_valid,
  output tcr_matcher_t         lk_matcher,
  output tcr_size_t            lk_size,
  output logic [DEF_IDX_W-1:0] lk_default,
  output logic [KEY_W-1:0]     lk_key
);
  initial begin
    lk_valid = 1'b0;
    lk_matcher = TCR_CLS0;
    lk_size = TCR_X4;
    lk_default = 5'h0;
    lk_key = '0;
  end
  // hold the request until ready is sampled high, default chosen with the key
  task automatic req(tcr_matcher_t m, tcr_size_t s, logic [4:0] d, logic [KEY_W-1:0] k);
    @(posedge clk);
    #1 {lk_valid, lk_matcher, lk_size, lk_default, lk_key} = {1'b1, m, s, d, k};
    do @(posedge clk); while (lk_ready_q !== 1'b1);
    #1 lk_valid = 1'b0;
    lk_key = ~k;
  endtask
endmodule // tcr_analyzer

// >>> test/tcr_lookup_bench.sv
// Purpose: self-checking bench of the lookup engine
// Assumes: 40 MHz clock, rule writes done by the bench in place of software
// Notes:   expectations queue up at the driver and are popped on each result

`timescale 1ns/10ps

module tcr_lookup_bench;
  import tcr_pkg::*;
  typedef struct packed {logic hit; logic [12:0] addr; logic act_on; logic [279:0] act;} tcr_exp_t;
  logic clk, sys_rst, wr_en, lk_valid, lk_ready_q, cnt_q, res_valid_q, res_hit_q;
  logic [3:0][2:0] blk_first;
  logic [3:0][3:0] blk_count;
  logic [12:0] wr_addr, cnt_addr, res_addr_q;
  logic [35:0] wr_entry, wr_mask;
  logic [69:0] wr_action;
  tcr_matcher_t lk_matcher;
  tcr_size_t lk_size;
  logic [4:0] lk_default;
  logic [575:0] lk_key, key;
  logic [279:0] res_action_q, act;
  tcr_exp_t exp_q[$], e;
  int fail_count = 0, samples_checked = 0, cyc = 0, d;
  tcr_lookup dut_u (.clk, .sys_rst, .blk_first, .blk_count, .wr_en, .wr_addr, .wr_entry,
    .wr_mask, .wr_action, .cnt_addr, .cnt_q, .lk_valid, .lk_ready_q, .lk_matcher, .lk_size,
    .lk_default, .lk_key, .res_valid_q, .res_hit_q, .res_addr_q, .res_action_q);
  tcr_analyzer an_u (.clk, .lk_ready_q, .lk_valid, .lk_matcher, .lk_size, .lk_default, .lk_key);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic conclude();
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // hang guard, far above any run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      fail_count++;
      conclude();
    end
  end
  task automatic check(string n, logic [279:0] seen, logic [279:0] want);
    samples_checked++;
    if (seen !== want) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, want, seen);
    end
  endtask
  // result watcher, sampled mid-cycle while the pulse stands
  always @(negedge clk) begin
    if (res_valid_q === 1'b1) begin
      e = exp_q.pop_front();
      check("hit", res_hit_q, e.hit);
      check("address", res_addr_q, e.addr);
      if (e.act_on) check("action", res_action_q, e.act);
    end
  end
  function automatic logic [12:0] defa(tcr_matcher_t m, int n);
    int mx;
    mx = (m == TCR_ACL) ? 15 : 29;
    return ((m == TCR_ACL) ? 13'h1da0 : 13'h1800 + 13'(480 * m)) + 13'((n > mx ? mx : n) * 16);
  endfunction
  task automatic lk(tcr_matcher_t m, tcr_size_t s, int n, logic h, logic [12:0] a, logic ao);
    exp_q.push_back('{h, a, ao, act});
    an_u.req(m, s, 5'(n), key);
  endtask
  task automatic wr(logic [12:0] a, logic [35:0] en, logic [69:0] ac);
    {wr_en, wr_addr, wr_entry, wr_mask, wr_action} = {1'b1, a, en, 36'h0, ac};
    @(posedge clk);
    #1;
  endtask
  initial begin
    void'($urandom(35));
    {sys_rst, wr_en, wr_addr, wr_entry, wr_mask, wr_action} = {1'b1, 156'h0};
    {cnt_addr, blk_first, blk_count, act} = {13'h404, 28'h0, 280'h0};
    repeat (5) @(posedge clk);
    #1 sys_rst = 1'b0;
    // no blocks: every matcher falls back, index at zero, clamped and random
    for (int m = 0; m < 4; m++) begin
      for (int j = 0; j < 3; j++) begin
        d = (j == 0) ? 0 : (j == 1) ? 31 : $urandom % 32;
        key = {18{$urandom}};
        lk(tcr_matcher_t'(m), TCR_X4, d, 1'b0, defa(tcr_matcher_t'(m), d), 1'b0);
      end
    end
    // one access-list block at 1024, cleared, then an X16 rule at 1040 and an X4 rule at 1028, high word first
    blk_first[3] = 3'h1;
    blk_count[3] = 4'h1;
    for (int a = 1024; a < 2048; a++) wr(13'(a), 36'h0, 70'h0);
    key = {18{$urandom}};
    for (int k = 15; k >= 0; k--) begin
      d = 36 * k - 3 * (k > 0) - (k > 4) - 2 * (k > 8) - (k > 12);
      wr(13'(1040 + k), key[d +: 36] << (k ? (k % 4 ? 0 : 1 + (k == 8)) : 3) | 4 * !k,
        '0);
      if (k < 4) begin
        act[70*k +: 70] = 70'({$urandom, $urandom, $urandom});
        wr(13'(1028 + k), k ? key[36*k-1 +: 36] : {key[34:0], 1'b1}, act[70*k +: 70]);
      end
    end
    wr_en = 1'b0;
    repeat (2) @(negedge clk);
    check("counter cleared", cnt_q, 1'b0);
    lk(TCR_ACL, TCR_X4, 3, 1'b1, 13'h404, 1'b1);
    lk(TCR_ACL, TCR_X16, 4, 1'b1, 13'h410, 1'b0);
    lk(TCR_ACL, TCR_X8, 1, 1'b0, defa(TCR_ACL, 1), 1'b0);
    lk(TCR_ACL, TCR_X1, 2, 1'b0, defa(TCR_ACL, 2), 1'b0);
    key[40] = ~key[40];
    lk(TCR_ACL, TCR_X4, 20, 1'b0, defa(TCR_ACL, 20), 1'b0);
    for (int i = 0; i < 3000 && exp_q.size() > 0; i++) @(posedge clk);
    repeat (3) @(negedge clk);
    check("results outstanding", 280'(exp_q.size()), 280'h0);
    check("counter set", cnt_q, 1'b1);
    conclude();
  end
endmodule // tcr_lookup_bench
